// File: hdl/smc_pkg.sv
// Package with constants and types for the sleep mode controller
package smc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] SMC_ADDR_CTRL      = 4'h0;
  localparam logic [3:0] SMC_ADDR_STATUS    = 4'h1;
  localparam logic [3:0] SMC_ADDR_IRQ_STAT  = 4'h2;
  localparam logic [3:0] SMC_ADDR_IRQ_MASK  = 4'h3;
  localparam logic [3:0] SMC_ADDR_TMR_LOAD  = 4'h4;

  // Control register fields
  localparam int SMC_CTRL_SE_BIT   = 0;
  localparam int SMC_CTRL_SM_LSB   = 1;
  localparam int SMC_CTRL_LFT_BIT  = 4;
  localparam logic [7:0] SMC_CTRL_RESET = 8'h00;

  // Interrupt status bits
  localparam int SMC_IRQ_PIN_BIT   = 0;
  localparam int SMC_IRQ_TMR_BIT   = 1;
  localparam int SMC_IRQ_WIDTH     = 2;

  // Sleep mode select encodings
  localparam logic [2:0] SMC_SM_IDLE     = 3'h0;
  localparam logic [2:0] SMC_SM_ADC_NR   = 3'h1;
  localparam logic [2:0] SMC_SM_PDOWN    = 3'h2;
  localparam logic [2:0] SMC_SM_PSAVE    = 3'h3;
  localparam logic [2:0] SMC_SM_STANDBY  = 3'h6;
  localparam logic [2:0] SMC_SM_EXT_STBY = 3'h7;

  localparam int SMC_PIN_COUNT = 6;
  localparam logic [15:0] SMC_TMR_LOAD_RESET = 16'h0020;

  typedef enum {
    SMC_ST_RUN,
    SMC_ST_SLEEP
  } smc_state_e;

endpackage

// File: hdl/smc_lf_timer.sv
// Wake timer ticking on the low-frequency oscillator strobe
`timescale 1ns/100ps
`default_nettype none
module smc_lf_timer
  import smc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        run_i,
  input  wire logic        lf_tick_i,
  input  wire logic [15:0] load_i,
  output logic             expire_o
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        exp_reg;
  logic        exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    exp_next = 1'b0;
    if (!run_i) begin
      cnt_next = load_i;
    end else if (lf_tick_i) begin
      if (cnt_reg <= 16'h0001) begin
        cnt_next = load_i;
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 16'h0000;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expire_o = exp_reg;

endmodule
`default_nettype wire

// File: hdl/smc_sleep_ctrl.sv
// Sleep mode controller: sleep entry, radio off, wake sources, registers
//
// Behaviour
// - Sleep only when sleep enable is one and the sleep instruction executes.
// - Three-bit mode select field chooses one of six sleep modes.
// - While sleeping the radio transceiver is held off.
// - Pin interrupts stay armed in power-down and wake the device.
// - Low-frequency timer can wake the device at regular intervals.
// - Idle with timer running is not offered on the small variant.
// - Reset pin is active low with an internal pull-up.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
)
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     reset_pin_n_i,
  input  wire logic                     reset_pin_oe_i,
  input  wire logic [3:0]               addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [7:0]               rdata_o,
  input  wire logic                     sleep_instr_i,
  input  wire logic [SMC_PIN_COUNT-1:0] pin_irq_i,
  input  wire logic                     lf_tick_i,
  output logic                          sleeping_o,
  output logic      [2:0]               active_mode_o,
  output logic                          radio_off_o,
  output logic                          cpu_run_o,
  output logic                          cpu_reset_o,
  output logic                          wake_o,
  output logic                          irq_o
);

  // ---------------------------------------------------------------
  // Reset pin with pull-up
  // ---------------------------------------------------------------
  // Undriven pin reads high, so the processor leaves reset
  logic pin_level;
  assign pin_level = reset_pin_oe_i ? reset_pin_n_i : 1'b1;

  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m == SMC_SM_IDLE) || (m == SMC_SM_ADC_NR) ||
                 (m == SMC_SM_PDOWN) || (m == SMC_SM_PSAVE) ||
                 (m == SMC_SM_STANDBY) || (m == SMC_SM_EXT_STBY);
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0]               ctrl_reg, ctrl_next;
  logic [SMC_IRQ_WIDTH-1:0] ist_reg, ist_next;
  logic [SMC_IRQ_WIDTH-1:0] imsk_reg, imsk_next;
  logic [15:0]              tload_reg, tload_next;
  logic [7:0]               rdata_reg, rdata_next;
  smc_state_e               state_reg, state_next;
  logic [2:0]               amode_reg, amode_next;
  logic                     wake_reg, wake_next;
  logic                     irq_reg, irq_next;
  logic                     sleep_reg, sleep_next;
  logic                     run_reg, run_next;
  logic                     creset_reg;
  logic                     tmr_exp;
  logic                     tmr_run;
  logic                     pin_any;
  logic                     lft_en;
  logic                     wake_ev;
  logic [2:0]               sel_mode;

  assign sel_mode = ctrl_reg[SMC_CTRL_SM_LSB +: 3];
  // Small variant cannot keep the timer alive in idle
  assign lft_en  = ctrl_reg[SMC_CTRL_LFT_BIT] && !SMALL_VARIANT;
  assign pin_any = |pin_irq_i;
  assign tmr_run = (state_reg == SMC_ST_SLEEP) && lft_en;

  smc_lf_timer u_timer (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .run_i     (tmr_run),
    .lf_tick_i (lf_tick_i),
    .load_i    (tload_reg),
    .expire_o  (tmr_exp)
  );

  // Pins wake from every mode, power-down included
  assign wake_ev = pin_any || tmr_exp;

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    amode_next = amode_reg;
    wake_next  = 1'b0;
    unique case (state_reg)
      SMC_ST_RUN: begin
        if (sleep_instr_i && ctrl_reg[SMC_CTRL_SE_BIT] &&
            mode_valid(sel_mode)) begin
          state_next = SMC_ST_SLEEP;
          amode_next = sel_mode;
        end
      end
      SMC_ST_SLEEP: begin
        if (wake_ev) begin
          state_next = SMC_ST_RUN;
          wake_next  = 1'b1;
        end
      end
    endcase
    // Output flops follow the next state, so they move with state_reg
    sleep_next = (state_next == SMC_ST_SLEEP);
    run_next   = (state_next == SMC_ST_RUN);
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_next  = ctrl_reg;
    imsk_next  = imsk_reg;
    tload_next = tload_reg;
    ist_next   = ist_reg;
    rdata_next = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        SMC_ADDR_CTRL:     ctrl_next = wdata_i;
        SMC_ADDR_IRQ_MASK: imsk_next = wdata_i[SMC_IRQ_WIDTH-1:0];
        SMC_ADDR_TMR_LOAD: tload_next = {8'h00, wdata_i};
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        SMC_ADDR_CTRL:     rdata_next = ctrl_reg;
        SMC_ADDR_STATUS:   rdata_next = {4'h0, amode_reg,
                                         state_reg == SMC_ST_SLEEP};
        SMC_ADDR_IRQ_STAT: rdata_next = {6'h00, ist_reg};
        SMC_ADDR_IRQ_MASK: rdata_next = {6'h00, imsk_reg};
        SMC_ADDR_TMR_LOAD: rdata_next = tload_reg[7:0];
        default:           rdata_next = 8'h00;
      endcase
      if (addr_i == SMC_ADDR_IRQ_STAT) begin
        ist_next = '0;
      end
    end
    // Set beats the read clear so no wake is lost
    if (state_reg == SMC_ST_SLEEP && pin_any) begin
      ist_next[SMC_IRQ_PIN_BIT] = 1'b1;
    end
    if (state_reg == SMC_ST_SLEEP && tmr_exp) begin
      ist_next[SMC_IRQ_TMR_BIT] = 1'b1;
    end
    irq_next = |(ist_next & imsk_next);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg   <= SMC_CTRL_RESET;
      imsk_reg   <= '0;
      tload_reg  <= SMC_TMR_LOAD_RESET;
      ist_reg    <= '0;
      rdata_reg  <= 8'h00;
      state_reg  <= SMC_ST_RUN;
      amode_reg  <= SMC_SM_IDLE;
      wake_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      creset_reg <= 1'b1;
      sleep_reg  <= 1'b0;
      run_reg    <= 1'b1;
    end else begin
      ctrl_reg   <= ctrl_next;
      imsk_reg   <= imsk_next;
      tload_reg  <= tload_next;
      ist_reg    <= ist_next;
      rdata_reg  <= rdata_next;
      state_reg  <= state_next;
      amode_reg  <= amode_next;
      wake_reg   <= wake_next;
      irq_reg    <= irq_next;
      creset_reg <= !pin_level;
      sleep_reg  <= sleep_next;
      run_reg    <= run_next;
    end
  end

  assign rdata_o       = rdata_reg;
  assign sleeping_o    = sleep_reg;
  assign radio_off_o   = sleep_reg;
  assign cpu_run_o     = run_reg;
  assign active_mode_o = amode_reg;
  assign wake_o        = wake_reg;
  assign irq_o         = irq_reg;
  assign cpu_reset_o   = creset_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_enter;
    !sleeping_o && sleep_instr_i && ctrl_reg[SMC_CTRL_SE_BIT] &&
    mode_valid(sel_mode);
  endsequence

  property p_enter;
    @(posedge clk_i) disable iff (reset_i)
    s_enter |=> sleeping_o && active_mode_o == $past(sel_mode);
  endproperty
  a_enter: assert property (p_enter)
    else $error("sleep not entered");

  property p_no_se;
    @(posedge clk_i) disable iff (reset_i)
    !sleeping_o && !ctrl_reg[SMC_CTRL_SE_BIT] |=> !sleeping_o;
  endproperty
  a_no_se: assert property (p_no_se)
    else $error("slept without enable");

  property p_mode_hold;
    @(posedge clk_i) disable iff (reset_i)
    sleeping_o |=> $stable(active_mode_o);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed while asleep");

  property p_radio;
    @(posedge clk_i) disable iff (reset_i)
    sleeping_o |-> radio_off_o && !cpu_run_o;
  endproperty
  a_radio: assert property (p_radio)
    else $error("radio on in sleep");

  sequence s_pin_wake;
    sleeping_o && pin_any;
  endsequence

  property p_pin_wake;
    @(posedge clk_i) disable iff (reset_i)
    s_pin_wake |=> !sleeping_o && wake_o;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("pin did not wake");

  property p_tmr_wake;
    @(posedge clk_i) disable iff (reset_i)
    sleeping_o && tmr_exp |=> !sleeping_o;
  endproperty
  a_tmr_wake: assert property (p_tmr_wake)
    else $error("timer did not wake");

  property p_small;
    @(posedge clk_i) disable iff (reset_i)
    SMALL_VARIANT |-> !tmr_run;
  endproperty
  a_small: assert property (p_small)
    else $error("timer run on small variant");

  property p_pullup;
    @(posedge clk_i) disable iff (reset_i)
    !reset_i && !reset_pin_oe_i |=> !cpu_reset_o;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("undriven pin held reset");

  property p_resume;
    @(posedge clk_i) disable iff (reset_i)
    $fell(sleeping_o) |-> cpu_run_o && wake_o && $stable(active_mode_o);
  endproperty
  a_resume: assert property (p_resume)
    else $error("bad resume");

endmodule
`default_nettype wire

// File: testbench/smc_wake_partner.sv
// Model of external wake switches and the optional reset supervisor
`timescale 1ns/100ps
`default_nettype none
module smc_wake_partner
  import smc_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic [SMC_PIN_COUNT-1:0] press_i,
  input  wire logic                     hold_reset_i,
  output logic      [SMC_PIN_COUNT-1:0] pin_irq_o,
  output logic                          reset_pin_n_o,
  output logic                          reset_pin_oe_o
);
  // Switches drive their lines at all times, low when idle
  always_ff @(posedge clk_i) pin_irq_o <= press_i;
  // Supervisor pulls low only while holding; pull-up wins otherwise
  assign reset_pin_oe_o = hold_reset_i;
  assign reset_pin_n_o  = hold_reset_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: testbench/smc_sleep_ctrl_tb_top.sv
// Self-checking bench for the sleep mode controller
`timescale 1ns/100ps
`default_nettype none
module smc_sleep_ctrl_tb_top import smc_pkg::*;;
  logic       clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic       sleep_instr_i = 1'b0, lf_tick_i = 1'b0, hold_reset = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [5:0] press = 6'h00;
  logic [7:0] rdata_o;
  logic [2:0] active_mode_o;
  logic [5:0] pin_irq;
  logic       sleeping_o, radio_off_o, cpu_run_o, cpu_reset_o, wake_o, irq_o;
  logic       rst_pin_n, rst_pin_oe, rd_d = 1'b0;
  logic       small_sleeping;
  logic [15:0] lfsr = 16'h9344;
  logic [7:0] exp_q[$];
  logic [2:0] modes[6] = '{SMC_SM_IDLE, SMC_SM_ADC_NR, SMC_SM_PDOWN,
                           SMC_SM_PSAVE, SMC_SM_STANDBY, SMC_SM_EXT_STBY};
  int         num_errors = 0, comparisons = 0, wakes = 0, ticks = 0, w = 0;

  smc_sleep_ctrl smc_sleep_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i),
    .reset_pin_n_i(rst_pin_n), .reset_pin_oe_i(rst_pin_oe), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sleep_instr_i(sleep_instr_i), .pin_irq_i(pin_irq), .lf_tick_i(lf_tick_i),
    .sleeping_o(sleeping_o), .active_mode_o(active_mode_o),
    .radio_off_o(radio_off_o), .cpu_run_o(cpu_run_o),
    .cpu_reset_o(cpu_reset_o), .wake_o(wake_o), .irq_o(irq_o));
  smc_wake_partner smc_wake_partner_inst (.clk_i(clk_i), .press_i(press),
    .hold_reset_i(hold_reset), .pin_irq_o(pin_irq),
    .reset_pin_n_o(rst_pin_n), .reset_pin_oe_o(rst_pin_oe));
  // Small variant shares all stimulus; its timer must never wake it
  smc_sleep_ctrl #(.SMALL_VARIANT(1'b1)) smc_sleep_ctrl_small_inst (
    .clk_i(clk_i), .reset_i(reset_i), .reset_pin_n_i(rst_pin_n),
    .reset_pin_oe_i(rst_pin_oe), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .sleep_instr_i(sleep_instr_i),
    .pin_irq_i(pin_irq), .lf_tick_i(lf_tick_i),
    .sleeping_o(small_sleeping), .active_mode_o(), .radio_off_o(),
    .cpu_run_o(), .cpu_reset_o(), .wake_o(), .irq_o());

  always #12.5 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] expd);
    comparisons++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic sleep_cmd();
    @(posedge clk_i);
    sleep_instr_i <= 1'b1;
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  // Wait bounded; a held wake pulse would show as extra counts
  task automatic wake_pin();
    w = wakes;
    lfsr = lfsr_next(lfsr);
    @(posedge clk_i);
    press <= 6'h01 << (lfsr % 16'd6);
    for (int i = 0; i < 8 && wakes == w; i++) @(posedge clk_i);
    press <= 6'h00;
    repeat (3) @(posedge clk_i);
    #1;
    check("wake count", 8'(wakes - w), 8'h01);
    check("sleeping", sleeping_o, 8'h00);
    check("cpu_run", cpu_run_o, 8'h01);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Result watcher: read data only in the cycle after a read
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rd_d) check("rdata", rdata_o, exp_q.pop_front());
    // Flops are unknown until the first edge under reset
    else if (!reset_i) check("rdata idle", rdata_o, 8'h00);
    rd_d <= rd_i;
    if (wake_o === 1'b1) wakes++;
  end

  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check("cpu_reset", cpu_reset_o, 8'h00);
    rd(SMC_ADDR_CTRL, SMC_CTRL_RESET);
    rd(SMC_ADDR_TMR_LOAD, SMC_TMR_LOAD_RESET[7:0]);
    lfsr = lfsr_next(lfsr);
    wr({1'b1, lfsr[2:0]}, lfsr[15:8]);
    rd({1'b1, lfsr[2:0]}, 8'h00);
    wr(SMC_ADDR_CTRL, {4'h0, SMC_SM_PDOWN, 1'b0});
    sleep_cmd();
    check("sleep without enable", sleeping_o, 8'h00);
    wr(SMC_ADDR_IRQ_MASK, 8'h01);
    foreach (modes[k]) begin
      wr(SMC_ADDR_CTRL, {4'h0, modes[k], 1'b1});
      sleep_cmd();
      check("sleeping", sleeping_o, 8'h01);
      check("mode", active_mode_o, {5'h0, modes[k]});
      check("radio_off", radio_off_o, 8'h01);
      check("cpu_run", cpu_run_o, 8'h00);
      rd(SMC_ADDR_STATUS, {4'h0, modes[k], 1'b1});
      wake_pin();
      check("irq", irq_o, 8'h01);
      rd(SMC_ADDR_IRQ_STAT, 8'h01);
      rd(SMC_ADDR_CTRL, {4'h0, modes[k], 1'b1});
      rd(SMC_ADDR_IRQ_STAT, 8'h00);
      #1 check("irq cleared", irq_o, 8'h00);
    end
    for (int m = 4; m < 6; m++) begin
      wr(SMC_ADDR_CTRL, {4'h0, 3'(m), 1'b1});
      sleep_cmd();
      check("bad mode", sleeping_o, 8'h00);
    end
    wr(SMC_ADDR_IRQ_MASK, 8'h00);
    wr(SMC_ADDR_CTRL, {4'h0, SMC_SM_PDOWN, 1'b1});
    sleep_cmd();
    wake_pin();
    check("masked irq", irq_o, 8'h00);
    rd(SMC_ADDR_IRQ_STAT, 8'h01);
    // Timer wake: expect exactly the load count of ticks
    wr(SMC_ADDR_IRQ_MASK, 8'h02);
    wr(SMC_ADDR_TMR_LOAD, 8'h03);
    rd(SMC_ADDR_TMR_LOAD, 8'h03);
    wr(SMC_ADDR_CTRL, 8'h11);
    sleep_cmd();
    w = wakes;
    for (int i = 0; i < 8 && wakes == w; i++) begin
      repeat (3) @(posedge clk_i);
      if (wakes == w) begin
        lf_tick_i <= 1'b1;
        @(posedge clk_i);
        lf_tick_i <= 1'b0;
        ticks++;
      end
    end
    check("timer ticks", 8'(ticks), 8'h03);
    check("irq timer", irq_o, 8'h01);
    check("small asleep", small_sleeping, 8'h01);
    rd(SMC_ADDR_IRQ_STAT, 8'h02);
    @(posedge clk_i);
    hold_reset <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check("cpu_reset held", cpu_reset_o, 8'h01);
    @(posedge clk_i);
    hold_reset <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 check("cpu_reset free", cpu_reset_o, 8'h00);
    repeat (2) @(posedge clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
